// *** bench/flash_erase_control_tb_top.sv ***
// Self-checking bench for the flash erase control block
`timescale 1ns/1ns
module flash_erase_control_tb_top
    import nvm_erase_pkg::*;
;
    // Short delays keep the run brief
    localparam int T_SETUP = 3;
    localparam int T_PAGE = 6;
    localparam int T_MASS = 8;
    localparam int T_HOLD = 2;
    localparam int T_MHOLD = 3;
    typedef struct {string nm; logic [16:0] v;} note_t;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_seen = 1'b0;
    logic [15:0] arr_addr = 16'h0000;
    logic arr_wr = 1'b0;
    logic [7:0] prot_val = 8'hFF;
    logic lock_req = 1'b0;
    logic [7:0] block_protect;
    logic locked;
    logic [7:0] rdata;
    logic pump_on, hv, erase_pulse, mass_pulse, trim_erased, ready;
    logic [15:0] page_base;
    logic [31:0] seed = 32'h396DAE2D;
    logic [15:0] a;
    int n_errors = 0;
    int check_count = 0;
    note_t rd_q[$];
    note_t pulse_q[$];

    // Free-running 50 MHz clock
    always #10 ref_clk = ~ref_clk;

    nvm_protect_model model_u (.ref_clk_i(ref_clk), .value_i(prot_val), .lock_i(lock_req),
        .protect_o(block_protect), .locked_o(locked));

    flash_erase_control #(.SETUP_DELAY(T_SETUP), .PAGE_ERASE_TIME(T_PAGE),
        .MASS_ERASE_TIME(T_MASS), .HOLD_DELAY(T_HOLD), .MASS_HOLD_DELAY(T_MHOLD),
        .RECOVERY_DELAY(1)) dut_u (
        .ref_clk_i(ref_clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .array_addr_i(arr_addr),
        .array_wr_i(arr_wr), .monitor_locked_i(locked), .block_protect_i(block_protect),
        .charge_pump_on_o(pump_on), .high_voltage_o(hv), .erase_pulse_o(erase_pulse),
        .mass_pulse_o(mass_pulse), .erase_page_base_o(page_base),
        .trim_erased_o(trim_erased), .array_ready_o(ready));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic check(input string nm, input logic [16:0] seen, input logic [16:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
    endtask

    // One-cycle strobes, then one idle edge so no signal is set twice in a step
    task automatic reg_write(input logic [3:0] ad, input logic [7:0] d);
        addr <= ad;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic reg_read(input logic [3:0] ad, input logic [7:0] d, input string nm);
        rd_q.push_back(note_t'{nm, {9'h000, d}});
        addr <= ad;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic arm_write(input logic [15:0] ad);
        arr_addr <= ad;
        arr_wr <= 1'b1;
        @(posedge ref_clk);
        arr_wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Bounded wait for outstanding pulses and the idle flag
    task automatic wait_idle();
        int i;
        for (i = 0; i < 40 && (pulse_q.size() != 0 || ready !== 1'b1); i++) @(posedge ref_clk);
        if (i == 40) begin
            n_errors++;
            $display("Error idle expected 1 seen timeout");
            close_out();
        end
    endtask

    // Software side of an erase; ok says whether high voltage may be granted
    task automatic erase_seq(input logic [15:0] ad, input logic m, input logic ok);
        logic [7:0] c;
        logic [15:0] b;
        c = m ? 8'h06 : 8'h02;
        b = (ad >= VECTOR_BASE) ? VECTOR_BASE : (ad & 16'hFFC0);
        reg_write(ADDR_CONTROL, c);
        reg_read(ADDR_PROTECT, prot_val, "protect");
        if (locked === 1'b1) reg_write(ADDR_PROTECT, 8'h5A);
        else arm_write(ad);
        reg_read(4'hF, 8'h00, "unrelated");
        repeat (T_SETUP + 2) @(posedge ref_clk);
        reg_write(ADDR_CONTROL, c | 8'h08);
        reg_read(ADDR_CONTROL, ok ? (c | 8'h08) : c, "control hv");
        check("pump", {16'h0000, pump_on}, {16'h0000, ok});
        check("hv", {16'h0000, hv}, {16'h0000, ok});
        repeat ((m ? T_MASS : T_PAGE) + 1) @(posedge ref_clk);
        if (ok) pulse_q.push_back(note_t'{"erase done", m ? 17'h10000 : {1'b0, b}});
        reg_write(ADDR_CONTROL, ok ? 8'h08 : 8'h00);
        repeat ((m ? T_MHOLD : T_HOLD) + 1) @(posedge ref_clk);
        reg_write(ADDR_CONTROL, 8'h00);
        wait_idle();
        check("pump off", {16'h0000, pump_on}, 17'h00000);
    endtask

    // Takes the oldest note whenever a result shows at the outputs
    always @(posedge ref_clk) begin
        note_t n;
        if (rd_seen) begin
            n = (rd_q.size() != 0) ? rd_q.pop_front() : note_t'{"read", 17'h1FFFF};
            check(n.nm, {9'h000, rdata}, n.v);
        end
        if (erase_pulse === 1'b1 || mass_pulse === 1'b1) begin
            n = (pulse_q.size() != 0) ? pulse_q.pop_front() : note_t'{"stray pulse", 17'h1FFFF};
            check(n.nm, mass_pulse ? 17'h10000 : {1'b0, page_base}, n.v);
        end
        rd_seen <= rd;
    end

    // Watchdog against a hung run
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        $display("Error watchdog expected finish seen timeout");
        close_out();
    end

    initial begin
        do_reset();
        reg_read(ADDR_CONTROL, CONTROL_RESET, "control reset");
        reg_read(4'hF, 8'h00, "unmapped");
        // Both selects at once, then the second select while the first is held
        reg_write(ADDR_CONTROL, 8'h03);
        reg_read(ADDR_CONTROL, 8'h00, "both selects");
        reg_write(ADDR_CONTROL, 8'h01);
        reg_write(ADDR_CONTROL, 8'h03);
        reg_read(ADDR_CONTROL, 8'h01, "second select");
        reg_write(ADDR_CONTROL, 8'h09);
        reg_read(ADDR_CONTROL, 8'h01, "hv no sequence");
        reg_write(ADDR_CONTROL, 8'h00);
        // Random ordinary pages below the vector area
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            a = {2'b11, seed[13:0]};
            if (a >= 16'hFF80) a[13] = 1'b0;
            erase_seq(a, 1'b0, 1'b1);
        end
        check("trim", {16'h0000, trim_erased}, 17'h00000);
        erase_seq(16'hFFE4, 1'b0, 1'b1);
        check("trim vec", {16'h0000, trim_erased}, 17'h00001);
        reg_read(ADDR_STATUS, {1'b0, ST_IDLE, 1'b1, 3'h7}, "status vec");
        prot_val <= 8'hFE;
        erase_seq(16'hC000, 1'b1, 1'b0);
        prot_val <= 8'h00;
        erase_seq(16'hC100, 1'b0, 1'b0);
        prot_val <= 8'hFF;
        do_reset();
        check("trim rst", {16'h0000, trim_erased}, 17'h00000);
        erase_seq(16'hC000, 1'b1, 1'b1);
        check("trim mass", {16'h0000, trim_erased}, 17'h00001);
        reg_read(ADDR_STATUS, {1'b0, ST_IDLE, 1'b1, 3'h7}, "status mass");
        lock_req <= 1'b1;
        @(posedge ref_clk);
        @(posedge ref_clk);
        erase_seq(16'hC000, 1'b1, 1'b1);
        check("queues", 17'(rd_q.size() + pulse_q.size()), 17'h00000);
        close_out();
    end
endmodule // flash_erase_control_tb_top

// *** bench/nvm_protect_model.sv ***
// Array-side model of the protect byte and the monitor lock level
`timescale 1ns/1ns
module nvm_protect_model (
    input wire logic ref_clk_i,
    input wire logic [7:0] value_i,
    input wire logic lock_i,
    output logic [7:0] protect_o,
    output logic locked_o
);
    // Byte lives in flash, so reset leaves it alone; FF opens all, 00 shuts all
    always_ff @(posedge ref_clk_i) begin
        protect_o <= value_i;
        locked_o <= lock_i;
    end
endmodule // nvm_protect_model

// *** inc/nvm_erase_pkg.sv ***
// Shared constants for the flash erase control block
package nvm_erase_pkg;
    // Register map, byte addresses on the plain register port
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_PROTECT = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_ARM = 4'h3;
    // Control field positions
    localparam int BIT_PGM_SEL = 0;
    localparam int BIT_ERASE_SEL = 1;
    localparam int BIT_MASS_SEL = 2;
    localparam int BIT_HV_EN = 3;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] PROTECT_NONE = 8'hFF;
    localparam logic [7:0] PROTECT_ALL = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // Array geometry
    localparam int PAGE_BYTES = 64;
    localparam int ROW_BYTES = 32;
    localparam int VECTOR_PAGE_BYTES = 48;
    localparam logic [15:0] VECTOR_BASE = 16'hFFD0;
    localparam logic [15:0] TRIM_ADDR = 16'hFFC0;
    localparam logic [15:0] ARRAY_BASE = 16'hC000;
    // Default delays in system clock cycles
    localparam int SETUP_CYC = 10;
    localparam int PAGE_ERASE_CYC = 64;
    localparam int MASS_ERASE_CYC = 128;
    localparam int HOLD_CYC = 5;
    localparam int MASS_HOLD_CYC = 100;
    localparam int RECOVERY_CYC = 1;
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_SELECTED, ST_CHECKED, ST_ARMED, ST_HIGH_V, ST_HOLD, ST_RECOVER
    } seq_state_t;
endpackage

// *** rtl/flash_erase_control.sv ***
// Flash erase and program control register with sequence interlocks
`timescale 1ns/1ns
module flash_erase_control
    import nvm_erase_pkg::*;
#(
    parameter int SETUP_DELAY = SETUP_CYC,
    parameter int PAGE_ERASE_TIME = PAGE_ERASE_CYC,
    parameter int MASS_ERASE_TIME = MASS_ERASE_CYC,
    parameter int HOLD_DELAY = HOLD_CYC,
    parameter int MASS_HOLD_DELAY = MASS_HOLD_CYC,
    parameter int RECOVERY_DELAY = RECOVERY_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [15:0] array_addr_i,
    input wire logic array_wr_i,
    input wire logic monitor_locked_i,
    input wire logic [7:0] block_protect_i,
    output logic charge_pump_on_o,
    output logic high_voltage_o,
    output logic erase_pulse_o,
    output logic mass_pulse_o,
    output logic [15:0] erase_page_base_o,
    output logic trim_erased_o,
    output logic array_ready_o
);
    localparam int TW = 16;

    // Every delay needs at least one cycle and must fit the timer width
    if (SETUP_DELAY < 1 || PAGE_ERASE_TIME < 1 || MASS_ERASE_TIME < 1 ||
        HOLD_DELAY < 1 || MASS_HOLD_DELAY < 1 || RECOVERY_DELAY < 1 ||
        SETUP_DELAY >= (1 << TW) || PAGE_ERASE_TIME >= (1 << TW) ||
        MASS_ERASE_TIME >= (1 << TW) || HOLD_DELAY >= (1 << TW) ||
        MASS_HOLD_DELAY >= (1 << TW) || RECOVERY_DELAY >= (1 << TW)) begin : g_bad_delay
        $error("flash_erase_control: delay parameter out of range");
    end

    logic pgm_sel, erase_sel, mass_sel, hv_en;
    seq_state_t state;
    logic protect_read;
    logic [15:0] target;
    logic mass_armed;
    logic timer_load;
    logic [TW-1:0] timer_count;
    logic timer_done;
    logic trim_erased;
    logic page_erased;
    logic ctl_wr, prot_rd, arm_wr, erase_was_sel;

    assign ctl_wr = reg_wr_i && reg_addr_i == ADDR_CONTROL;
    assign prot_rd = reg_rd_i && reg_addr_i == ADDR_PROTECT;
    // Secure-failed monitor arms mass erase by a write to the protect address
    assign arm_wr = monitor_locked_i ? (reg_wr_i && reg_addr_i == ADDR_PROTECT)
                                     : array_wr_i;

    // Protection: all ones opens everything, all zeros shuts everything, otherwise compare the start page
    function automatic logic is_protected(input logic [7:0] bpr, input logic [15:0] a);
        logic [15:0] start;
        start = {2'b11, bpr, 6'h00};
        if (bpr == PROTECT_NONE) begin
            return 1'b0;
        end else if (bpr == PROTECT_ALL) begin
            return 1'b1;
        end
        return a >= start;
    endfunction

    // Page base: vector area forms one page, others align to 64 bytes
    function automatic logic [15:0] page_base(input logic [15:0] a);
        if (a >= VECTOR_BASE) begin
            return VECTOR_BASE;
        end
        return {a[15:6], 6'h00};
    endfunction

    logic target_prot;
    logic mass_blocked;
    assign target_prot = is_protected(block_protect_i, target);
    assign mass_blocked = block_protect_i != PROTECT_NONE;

    // Select bits; a write setting both is dropped so neither becomes one
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pgm_sel <= CONTROL_RESET[BIT_PGM_SEL];
            erase_sel <= CONTROL_RESET[BIT_ERASE_SEL];
            mass_sel <= CONTROL_RESET[BIT_MASS_SEL];
        end else if (ctl_wr) begin
            if (!(reg_wdata_i[BIT_PGM_SEL] && reg_wdata_i[BIT_ERASE_SEL])) begin
                if (!(reg_wdata_i[BIT_PGM_SEL] && erase_sel)) begin
                    pgm_sel <= reg_wdata_i[BIT_PGM_SEL];
                end
                if (!(reg_wdata_i[BIT_ERASE_SEL] && pgm_sel)) begin
                    erase_sel <= reg_wdata_i[BIT_ERASE_SEL];
                end
            end
            mass_sel <= reg_wdata_i[BIT_MASS_SEL];
        end
    end

    // High voltage only after the arming steps and outside protected memory
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            hv_en <= CONTROL_RESET[BIT_HV_EN];
        end else if (ctl_wr) begin
            if (!reg_wdata_i[BIT_HV_EN]) begin
                hv_en <= 1'b0;
            end else if (!hv_en && state == ST_ARMED && timer_done &&
                         protect_read && (pgm_sel || erase_sel) && !target_prot &&
                         !(mass_armed && mass_blocked)) begin
                hv_en <= 1'b1;
            end
        end
    end

    assign charge_pump_on_o = hv_en;
    assign high_voltage_o = hv_en;

    // Step tracker; unrelated accesses between steps do not disturb it
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            protect_read <= 1'b0;
            target <= 16'h0000;
            mass_armed <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (pgm_sel || erase_sel) begin
                        state <= ST_SELECTED;
                    end
                end
                ST_SELECTED: begin
                    if (!pgm_sel && !erase_sel) begin
                        state <= ST_IDLE;
                    end else if (prot_rd) begin
                        state <= ST_CHECKED;
                    end
                end
                ST_CHECKED: begin
                    if (!pgm_sel && !erase_sel) begin
                        state <= ST_IDLE;
                    end else if (arm_wr) begin
                        state <= ST_ARMED;
                        target <= monitor_locked_i ? ARRAY_BASE : array_addr_i;
                        mass_armed <= erase_sel && mass_sel;
                    end
                end
                ST_ARMED: begin
                    if (hv_en) begin
                        state <= ST_HIGH_V;
                    end else if (!pgm_sel && !erase_sel) begin
                        state <= ST_IDLE;
                    end
                end
                ST_HIGH_V: begin
                    if (!hv_en) begin
                        state <= ST_RECOVER;
                    end else if (!pgm_sel && !erase_sel) begin
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (!hv_en) begin
                        state <= ST_RECOVER;
                    end
                end
                ST_RECOVER: begin
                    if (timer_done) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
            protect_read <= (state == ST_SELECTED && prot_rd) ? 1'b1 :
                            (state == ST_IDLE) ? 1'b0 : protect_read;
        end
    end

    // Timer load on the arm, high-voltage, hold and recovery step edges with the matching delay
    always_comb begin
        timer_load = 1'b0;
        timer_count = '0;
        if (state == ST_CHECKED && arm_wr) begin
            timer_load = 1'b1;
            timer_count = TW'(SETUP_DELAY);
        end else if (state == ST_ARMED && hv_en) begin
            timer_load = 1'b1;
            timer_count = mass_armed ? TW'(MASS_ERASE_TIME) : TW'(PAGE_ERASE_TIME);
        end else if (state == ST_HIGH_V && !pgm_sel && !erase_sel) begin
            timer_load = 1'b1;
            timer_count = mass_armed ? TW'(MASS_HOLD_DELAY) : TW'(HOLD_DELAY);
        end else if ((state == ST_HIGH_V || state == ST_HOLD) && !hv_en) begin
            timer_load = 1'b1;
            timer_count = TW'(RECOVERY_DELAY);
        end
    end

    nvm_delay_timer #(.WIDTH(TW)) u_timer (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .load_i(timer_load),
        .count_i(timer_count),
        .done_o(timer_done)
    );

    function automatic logic mass_blocked_or_page(input logic m);
        return m ? mass_blocked : 1'b0;
    endfunction

    // Erase commits when the full erase time ran before the select cleared;
    // the hold reload in this same cycle does not hide the expired count
    logic erase_commit;
    assign erase_commit = state == ST_HIGH_V && !pgm_sel && !erase_sel && timer_done &&
                          !mass_blocked_or_page(mass_armed);

    logic erase_pulse, mass_pulse;
    assign erase_pulse = erase_commit && !mass_armed && erase_was_sel;
    assign mass_pulse = erase_commit && mass_armed;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            erase_was_sel <= 1'b0;
        end else if (state == ST_CHECKED && arm_wr) begin
            erase_was_sel <= erase_sel;
        end
    end

    // Registered erase outputs toward the array
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            erase_pulse_o <= 1'b0;
            mass_pulse_o <= 1'b0;
            erase_page_base_o <= 16'h0000;
        end else begin
            erase_pulse_o <= erase_pulse;
            mass_pulse_o <= mass_pulse;
            erase_page_base_o <= page_base(target);
        end
    end

    // Trim byte lost with a vector page or mass erase
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            trim_erased <= 1'b0;
        end else if (mass_pulse || (erase_pulse && page_base(target) == VECTOR_BASE)) begin
            trim_erased <= 1'b1;
        end
    end
    assign trim_erased_o = trim_erased;
    assign array_ready_o = state == ST_IDLE;

    nvm_page_store #(.PAGES(1024)) u_pages (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .page_clear_i(erase_pulse),
        .page_i(target[15:6]),
        .mass_clear_i(mass_pulse),
        .mark_i(state == ST_HIGH_V && pgm_sel),
        .rd_page_i(array_addr_i[15:6]),
        .erased_o(page_erased)
    );

    // Register read port, data one cycle after the strobe
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_CONTROL: reg_rdata_o <= {4'h0, hv_en, mass_sel, erase_sel, pgm_sel};
                ADDR_PROTECT: reg_rdata_o <= block_protect_i;
                ADDR_STATUS: reg_rdata_o <= {1'b0, state, trim_erased,
                                             page_erased ? ERASED_BYTE[2:0] : 3'h0};
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // Cycles since the arming write, saturating, to check the setup wait
    logic [TW-1:0] since_arm;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || (state == ST_CHECKED && arm_wr)) begin
            since_arm <= '0;
        end else if (since_arm != '1) begin
            since_arm <= since_arm + 1'b1;
        end
    end

    // Interlock and gating checks
    sequence hv_rise_s;
        !hv_en ##1 hv_en;
    endsequence

    interlock_sel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !(pgm_sel && erase_sel)) else $error("both select bits set");
    hv_needs_sel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        hv_rise_s |-> $past(pgm_sel || erase_sel)) else $error("hv set without select");
    hv_prot_block_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        hv_rise_s |-> !$past(target_prot)) else $error("hv set on protected target");
    mass_block_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        mass_pulse |-> block_protect_i == PROTECT_NONE) else $error("mass erase while protected");
    pump_follow_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        charge_pump_on_o == hv_en && high_voltage_o == hv_en) else $error("pump mismatch");
    trim_loss_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        mass_pulse |=> trim_erased) else $error("trim not erased");
    erase_out_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        erase_pulse |=> erase_pulse_o ##1 !erase_pulse_o) else $error("erase pulse shape");
    hv_setup_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        hv_rise_s |-> $past(since_arm) >= TW'(SETUP_DELAY)) else $error("hv before setup");
endmodule // flash_erase_control

// *** rtl/nvm_delay_timer.sv ***
// Down counter that reports when a programmed delay has run out
`timescale 1ns/1ns
module nvm_delay_timer #(
    parameter int WIDTH = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] count_i,
    output logic done_o
);
    logic [WIDTH-1:0] remain;

    if (WIDTH < 1) begin : g_bad_width
        $error("nvm_delay_timer: width must be positive");
    end

    // Reload wins over counting so a restart never sees a stale done
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            remain <= '0;
        end else if (load_i) begin
            remain <= count_i;
        end else if (remain != '0) begin
            remain <= remain - 1'b1;
        end
    end

    // Done reads the count alone, so a reload in the same cycle still sees expiry
    assign done_o = remain == '0;
endmodule // nvm_delay_timer

// *** rtl/nvm_page_store.sv ***
// Erase target memory: one erased flag per page, registered read
`timescale 1ns/1ns
module nvm_page_store #(
    parameter int PAGES = 256
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic page_clear_i,
    input wire logic [$clog2(PAGES)-1:0] page_i,
    input wire logic mass_clear_i,
    input wire logic mark_i,
    input wire logic [$clog2(PAGES)-1:0] rd_page_i,
    output logic erased_o
);
    logic [PAGES-1:0] erased;

    if (PAGES < 2) begin : g_bad_pages
        $error("nvm_page_store: at least two pages needed");
    end

    // Each page flag is cleared to erased by its own page clear or by the mass clear, untouched by other pages
    for (genvar p = 0; p < PAGES; p++) begin : g_page
        always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
                erased[p] <= 1'b0;
            end else if (mass_clear_i || (page_clear_i && page_i == p)) begin
                erased[p] <= 1'b1;
            end else if (mark_i && page_i == p) begin
                erased[p] <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            erased_o <= 1'b0;
        end else begin
            erased_o <= erased[rd_page_i];
        end
    end
endmodule // nvm_page_store
